/* vmt_defines.vh */
`ifndef VMT_DEFINES_VH
`define VMT_DEFINES_VH
// Register offsets
`define VMT_REG_MODE 8'h10
`define VMT_REG_OPT_A 8'h11
`define VMT_REG_QCK 8'h14
`define VMT_REG_OPT_B 8'h16
`define VMT_REG_PARTNER 8'h18
`define VMT_REG_XOFF_HI 8'h58
`define VMT_REG_XOFF_LO 8'h59
`define VMT_REG_YOFF_HI 8'h5a
`define VMT_REG_YOFF_LO 8'h5b
`define VMT_REG_LINE_HI 8'h60
`define VMT_REG_LINE_LO 8'h61
`define VMT_REG_FIELD_HI 8'h62
`define VMT_REG_FIELD_LO 8'h63
`define VMT_REG_CLKDIV 8'h64
// Field positions
`define VMT_RATE_BIT 3
`define VMT_BLACK_BIT 5
`define VMT_SHUFFLE_BIT 7
`define VMT_PREDIV_BIT 7
`define VMT_PARTNER_BIT 0
// Mode codes in bits [1:0] of the mode register
`define VMT_MODE_FULL 2'h0
`define VMT_MODE_BCAST 2'h1
`define VMT_MODE_CROP 2'h2
`define VMT_MODE_SUBS 2'h3
// Reset values and the free clock setup code
`define VMT_RST_MODE 8'h00
`define VMT_RST_OPT_A 8'h80
`define VMT_RST_PARTNER 8'h01
`define VMT_QCK_FREE 8'h04
// Line and field lengths minus one
`define VMT_LINE_PAL 9'h1c5
`define VMT_LINE_NTSC 9'h16b
`define VMT_LINE_F25 9'h1f3
`define VMT_LINE_F30 9'h19f
`define VMT_LINE_Q25 9'h0f9
`define VMT_LINE_Q30 9'h0cf
`define VMT_FIELD_PAL 9'h137
`define VMT_FIELD_NTSC 9'h105
`define VMT_FIELD_FULL 9'h13f
`define VMT_FIELD_Q 9'h09f
// System clock divisors
`define VMT_DIV_BCAST 4'h2
`define VMT_DIV_FULL 4'h4
`define VMT_DIV_Q 4'h8
// Image sizes and fixed offsets
`define VMT_W_FULL 9'h164
`define VMT_H_FULL 9'h124
`define VMT_W_NTSC 9'h132
`define VMT_H_NTSC 9'h0f4
`define VMT_W_Q 9'h0b4
`define VMT_H_Q 9'h094
`define VMT_X_FULL 9'h005
`define VMT_Y_FULL 9'h005
`define VMT_X_NTSC 9'h01d
`define VMT_Y_NTSC 9'h01d
`define VMT_X_Q 9'h05d
`define VMT_Y_Q 9'h04d
// Cropped offset limits and row classes
`define VMT_X_MIN 9'h001
`define VMT_X_MAX 9'h0b9
`define VMT_Y_MIN 9'h005
`define VMT_Y_MAX 9'h095
`define VMT_ROW_VIS_MIN 9'h005
`define VMT_ROW_VIS_MAX 9'h128
`define VMT_BLACK_ROW0 9'h001
`define VMT_BLACK_ROWS 9'h004
`endif

/* vmt_span_ctr.v */
`timescale 1ns/100ps
// Wrapping position counter shared by the pixel and line dimensions
module vmt_span_ctr #(
  parameter WIDTH = 9
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Control
  input wire clr,
  input wire en,
  input wire [WIDTH-1:0] last,
  // Status
  output reg [WIDTH-1:0] count,
  output wire wrap
);

  // Wrap is taken on the last count; a shortened limit also wraps at once
  assign wrap = en && (count >= last);

  // Counter restarts from zero on clear so leaving low power is clean
  always @(posedge ref_clk) begin
    if (sys_rst || clr) begin
      count <= {WIDTH{1'b0}};
    end else if (wrap) begin
      count <= {WIDTH{1'b0}};
    end else if (en) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

/* vmt_clk_gen.v */
`timescale 1ns/100ps
`include "vmt_defines.vh"
// Pixel tick generator: optional 1.5 pre-divider, then system times pixel divisor
module vmt_clk_gen (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Setup
  input wire run,
  input wire pre_div_en,
  input wire [3:0] sys_div,
  input wire [3:0] pix_div,
  // Pixel rate enable
  output reg tick
);

  reg [1:0] pre_cnt;
  reg [7:0] div_cnt;
  wire pre_tick;
  wire [8:0] total;
  wire [7:0] div_last;

  // Two enables in every three cycles gives the 1.5 pre-division
  assign pre_tick = run && (!pre_div_en || (pre_cnt != 2'h2));
  // Divisor 0 in the low nibble means divide by one of the pixel clock
  assign total = {5'h00, sys_div} * {4'h0, ({1'b0, pix_div} + 5'h01)};
  assign div_last = total[7:0] - 8'h01;

  // Pre-divider phase
  always @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      pre_cnt <= 2'h0;
    end else if (pre_cnt == 2'h2) begin
      pre_cnt <= 2'h0;
    end else begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end

  // Main divider; a zero system divisor ticks on every enable, whatever the pixel divisor
  always @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_tick) begin
        if (div_cnt >= div_last || total == 9'h000) begin
          div_cnt <= 8'h00;
          tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

endmodule

/* vmt_timing_top.v */
`timescale 1ns/100ps
`include "vmt_defines.vh"
// Video mode timing and readout address control
module vmt_timing_top (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Register port from the serial interface
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Power control
  input wire low_power,
  // Readout address and qualifiers
  output reg [8:0] x_addr,
  output reg [8:0] y_addr,
  output reg pix_valid,
  output reg black_line,
  output reg line_start,
  output reg field_start,
  output reg odd_field,
  // Frame grabber setup
  output wire qck_free_en,
  output wire shuffle_en
);

  // Host-visible setup registers
  reg [7:0] mode;
  reg [7:0] opt_a;
  reg [7:0] qck_setup;
  reg [7:0] opt_b;
  reg [7:0] partner;

  // Timing lengths, divisor and cropped offsets
  reg [8:0] line_len;
  reg [8:0] field_len;
  reg [7:0] clk_div;
  reg [8:0] x_off;
  reg [8:0] y_off;

  // Values a mode write forces into the dependent registers
  reg [8:0] next_line;
  reg [8:0] next_field;
  reg [3:0] next_div;
  reg next_bcast;

  // Window size and origin of the selected mode
  reg [8:0] img_w;
  reg [8:0] img_h;
  reg [8:0] x_base;
  reg [8:0] y_base;

  // Position within the window after shuffle and subsampling
  reg [8:0] x_pos;
  reg [8:0] y_pos;
  reg [8:0] shuf;

  // Clamped offsets and read data
  reg [8:0] clamp_x;
  reg [8:0] clamp_y;
  reg [7:0] next_rdata;

  // Mode decode and rate enable
  wire run;
  wire tick;
  wire mode_wr;
  wire [1:0] cur_mode;
  wire subs;
  wire black_en;

  // Raster counters
  wire [8:0] hcnt;
  wire [8:0] vcnt;
  wire hwrap;
  wire vwrap;
  wire [8:0] v_last;

  // Window qualifiers and next addresses
  wire [8:0] half_w;
  wire [8:0] blk_idx;
  wire h_act;
  wire v_act;
  wire blk_act;
  wire [8:0] x_next;
  wire [8:0] y_next;
  wire row_vis;

  // Decodes and setup outputs come straight from the registers
  assign run = !low_power;
  assign mode_wr = reg_wr && (reg_addr == `VMT_REG_MODE);
  assign cur_mode = mode[1:0];
  assign subs = (cur_mode == `VMT_MODE_SUBS);
  assign qck_free_en = (qck_setup == `VMT_QCK_FREE);
  assign shuffle_en = opt_a[`VMT_SHUFFLE_BIT];
  assign black_en = opt_a[`VMT_BLACK_BIT];

  // Values a mode write forces, taken from the byte being written
  always @* begin
    next_bcast = 1'b0;
    case (reg_wdata[1:0])
      `VMT_MODE_FULL: begin
        // Same 320 lines for both rates; only the line is stretched
        next_line = reg_wdata[`VMT_RATE_BIT] ? `VMT_LINE_F25 : `VMT_LINE_F30;
        next_field = `VMT_FIELD_FULL;
        next_div = `VMT_DIV_FULL;
      end
      `VMT_MODE_BCAST: begin
        // Rate bit picks 50 field timing over 60 field timing
        next_line = reg_wdata[`VMT_RATE_BIT] ? `VMT_LINE_PAL : `VMT_LINE_NTSC;
        next_field = reg_wdata[`VMT_RATE_BIT] ? `VMT_FIELD_PAL : `VMT_FIELD_NTSC;
        next_div = `VMT_DIV_BCAST;
        next_bcast = 1'b1;
      end
      default: begin
        next_line = reg_wdata[`VMT_RATE_BIT] ? `VMT_LINE_Q25 : `VMT_LINE_Q30;
        next_field = `VMT_FIELD_Q;
        next_div = `VMT_DIV_Q;
      end
    endcase
  end

  // Clamp cropped offsets so a bad write never leaves the permitted window
  always @* begin
    clamp_x = {x_off[8], reg_wdata};
    if (reg_addr == `VMT_REG_XOFF_HI) begin
      clamp_x = {reg_wdata[0], x_off[7:0]};
    end
    if (clamp_x < `VMT_X_MIN) begin
      clamp_x = `VMT_X_MIN;
    end else if (clamp_x > `VMT_X_MAX) begin
      clamp_x = `VMT_X_MAX;
    end
    clamp_y = {y_off[8], reg_wdata};
    if (reg_addr == `VMT_REG_YOFF_HI) begin
      clamp_y = {reg_wdata[0], y_off[7:0]};
    end
    if (clamp_y < `VMT_Y_MIN) begin
      clamp_y = `VMT_Y_MIN;
    end else if (clamp_y > `VMT_Y_MAX) begin
      clamp_y = `VMT_Y_MAX;
    end
  end

  // Register file; a mode write overrides the dependent registers
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mode <= `VMT_RST_MODE;
      opt_a <= `VMT_RST_OPT_A;
      qck_setup <= 8'h00;
      opt_b <= 8'h00;
      partner <= `VMT_RST_PARTNER;
      line_len <= `VMT_LINE_F30;
      field_len <= `VMT_FIELD_FULL;
      clk_div <= {`VMT_DIV_FULL, 4'h0};
      x_off <= `VMT_X_Q;
      y_off <= `VMT_Y_Q;
    end else if (mode_wr) begin
      // Overwrites regardless of what the host put there before
      mode <= reg_wdata;
      line_len <= next_line;
      field_len <= next_field;
      clk_div <= {next_div, 4'h0};
      qck_setup <= next_bcast ? `VMT_QCK_FREE : 8'h00;
      // Without the preferred partner the extra lines stay on in any mode
      opt_a[`VMT_BLACK_BIT] <= next_bcast || !partner[`VMT_PARTNER_BIT];
      // Cropped window goes back to the centre
      x_off <= `VMT_X_Q;
      y_off <= `VMT_Y_Q;
    end else if (reg_wr) begin
      case (reg_addr)
        `VMT_REG_OPT_A: opt_a <= reg_wdata;
        `VMT_REG_QCK: qck_setup <= reg_wdata;
        `VMT_REG_OPT_B: opt_b <= reg_wdata;
        `VMT_REG_PARTNER: partner <= reg_wdata;
        `VMT_REG_LINE_HI: line_len <= {reg_wdata[0], line_len[7:0]};
        `VMT_REG_LINE_LO: line_len <= {line_len[8], reg_wdata};
        `VMT_REG_FIELD_HI: field_len <= {reg_wdata[0], field_len[7:0]};
        `VMT_REG_FIELD_LO: field_len <= {field_len[8], reg_wdata};
        // Host reaches only the pixel divisor nibble
        `VMT_REG_CLKDIV: clk_div <= {clk_div[7:4], reg_wdata[3:0]};
        `VMT_REG_XOFF_HI: x_off <= clamp_x;
        `VMT_REG_XOFF_LO: x_off <= clamp_x;
        `VMT_REG_YOFF_HI: y_off <= clamp_y;
        `VMT_REG_YOFF_LO: y_off <= clamp_y;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    case (reg_addr)
      `VMT_REG_MODE: next_rdata = mode;
      `VMT_REG_OPT_A: next_rdata = opt_a;
      `VMT_REG_QCK: next_rdata = qck_setup;
      `VMT_REG_OPT_B: next_rdata = opt_b;
      `VMT_REG_PARTNER: next_rdata = partner;
      `VMT_REG_XOFF_HI: next_rdata = {7'h00, x_off[8]};
      `VMT_REG_XOFF_LO: next_rdata = x_off[7:0];
      `VMT_REG_YOFF_HI: next_rdata = {7'h00, y_off[8]};
      `VMT_REG_YOFF_LO: next_rdata = y_off[7:0];
      `VMT_REG_LINE_HI: next_rdata = {7'h00, line_len[8]};
      `VMT_REG_LINE_LO: next_rdata = line_len[7:0];
      `VMT_REG_FIELD_HI: next_rdata = {7'h00, field_len[8]};
      `VMT_REG_FIELD_LO: next_rdata = field_len[7:0];
      `VMT_REG_CLKDIV: next_rdata = clk_div;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is held until the next read strobe
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Pixel rate from the input clock
  vmt_clk_gen u_clk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(run),
    .pre_div_en(opt_b[`VMT_PREDIV_BIT]),
    .sys_div(clk_div[7:4]),
    .pix_div(clk_div[3:0]),
    .tick(tick)
  );

  // Broadcast timing alternates fields of n and n+1 lines
  assign v_last = field_len + {8'h00, (cur_mode == `VMT_MODE_BCAST) && odd_field};

  // Counters are cleared in low power, so wake-up starts a fresh field
  vmt_span_ctr #(.WIDTH(9)) u_hctr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clr(low_power),
    .en(tick),
    .last(line_len),
    .count(hcnt),
    .wrap(hwrap)
  );

  vmt_span_ctr #(.WIDTH(9)) u_vctr (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clr(low_power),
    .en(hwrap),
    .last(v_last),
    .count(vcnt),
    .wrap(vwrap)
  );

  // Image size and base offset per mode; only cropped mode takes host offsets
  always @* begin
    case (cur_mode)
      `VMT_MODE_BCAST: begin
        // 60 field timing uses the smaller window, shifted onto a green start
        img_w = mode[`VMT_RATE_BIT] ? `VMT_W_FULL : `VMT_W_NTSC;
        img_h = mode[`VMT_RATE_BIT] ? `VMT_H_FULL : `VMT_H_NTSC;
        x_base = mode[`VMT_RATE_BIT] ? `VMT_X_FULL : `VMT_X_NTSC;
        y_base = mode[`VMT_RATE_BIT] ? `VMT_Y_FULL : `VMT_Y_NTSC;
      end
      `VMT_MODE_CROP: begin
        img_w = `VMT_W_Q;
        img_h = `VMT_H_Q;
        // Low offsets reach the guard columns outside the full image
        x_base = x_off;
        y_base = y_off;
      end
      `VMT_MODE_SUBS: begin
        img_w = `VMT_W_Q;
        img_h = `VMT_H_Q;
        x_base = `VMT_X_FULL;
        y_base = `VMT_Y_FULL;
      end
      default: begin
        // Four spare columns each side; the rows fill the whole visible range, no spare rows
        img_w = `VMT_W_FULL;
        img_h = `VMT_H_FULL;
        x_base = `VMT_X_FULL;
        y_base = `VMT_Y_FULL;
      end
    endcase
  end

  // Window qualifiers; rows past the image feed the extra black lines
  assign half_w = {1'b0, img_w[8:1]};
  assign h_act = (hcnt < img_w);
  assign v_act = (vcnt < img_h);
  assign blk_idx = vcnt - img_h;
  assign blk_act = black_en && !v_act && (blk_idx < `VMT_BLACK_ROWS);

  // Column order: shuffle groups same-colour pixels; subsampling keeps 2 of 4
  always @* begin
    shuf = hcnt;
    if (shuffle_en) begin
      if (hcnt < half_w) begin
        shuf = {hcnt[7:0], 1'b0};
      end else begin
        shuf = {(hcnt[7:0] - half_w[7:0]), 1'b1};
      end
    end
    x_pos = subs ? {shuf[7:1], 1'b0, shuf[0]} : shuf;
    y_pos = subs ? {vcnt[7:1], 1'b0, vcnt[0]} : vcnt;
  end

  // Next addresses; black rows count up from the first black row
  assign x_next = x_base + x_pos;
  assign y_next = blk_act ? (`VMT_BLACK_ROW0 + blk_idx) : (y_base + y_pos);
  // Black and dark rows never count as image
  assign row_vis = (y_next >= `VMT_ROW_VIS_MIN) && (y_next <= `VMT_ROW_VIS_MAX);

  // Address outputs update on each pixel tick
  always @(posedge ref_clk) begin
    if (sys_rst || low_power) begin
      x_addr <= 9'h000;
      y_addr <= 9'h000;
      pix_valid <= 1'b0;
      black_line <= 1'b0;
      line_start <= 1'b0;
      field_start <= 1'b0;
    end else begin
      pix_valid <= tick && h_act && v_act && row_vis;
      black_line <= tick && h_act && blk_act;
      line_start <= tick && (hcnt == 9'h000);
      field_start <= tick && (hcnt == 9'h000) && (vcnt == 9'h000);
      if (tick) begin
        x_addr <= x_next;
        y_addr <= y_next;
      end
    end
  end

  // Field parity; kept across low power so interlace order survives
  always @(posedge ref_clk) begin
    if (sys_rst || mode_wr) begin
      odd_field <= 1'b0;
    end else if (vwrap) begin
      odd_field <= !odd_field;
    end
  end

endmodule

/* vmt_timing_properties.sv */
`timescale 1ns/100ps
// Port-level checks on the timing and readout block
module vmt_timing_properties (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Power and readout
  input wire low_power,
  input wire [8:0] x_addr,
  input wire [8:0] y_addr,
  input wire pix_valid,
  input wire black_line,
  input wire line_start,
  input wire field_start,
  input wire odd_field,
  input wire qck_free_en,
  input wire shuffle_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Outputs settle one cycle after low power is seen, so two samples are needed
  a_low_power_quiet: assert property (low_power && $past(low_power) |->
    !pix_valid && !black_line && x_addr == 9'h000 && y_addr == 9'h000)
    else $error("outputs active in low power");
  a_mode_sets_div: assert property ((reg_wr && reg_addr == 8'h10 &&
    reg_wdata[1:0] == 2'h0 ##2 reg_rd && reg_addr == 8'h64) |=> reg_rdata == 8'h40)
    else $error("full mode clock division wrong");
  a_qck_write: assert property (reg_wr && reg_addr == 8'h14 |=>
    qck_free_en == ($past(reg_wdata) == 8'h04))
    else $error("free clock enable wrong after setup write");
  a_qck_by_mode: assert property (reg_wr && reg_addr == 8'h10 |=>
    qck_free_en == ($past(reg_wdata[1:0]) == 2'h1))
    else $error("free clock enable wrong after mode write");
  a_shuffle_write: assert property (reg_wr && reg_addr == 8'h11 |=>
    shuffle_en == $past(reg_wdata[7]))
    else $error("shuffle enable does not follow register");
  a_visible_rows: assert property (pix_valid |->
    y_addr >= 9'h005 && y_addr <= 9'h128)
    else $error("visible pixel on a black or dark row");
  a_visible_cols: assert property (pix_valid |->
    x_addr >= 9'h001 && x_addr <= 9'h16c)
    else $error("visible pixel outside the array");
  a_black_rows: assert property (black_line |->
    y_addr >= 9'h001 && y_addr <= 9'h004)
    else $error("black line pixel outside black rows");
  a_field_on_line: assert property (field_start |-> line_start)
    else $error("field start without line start");
  a_mode_odd_clear: assert property (reg_wr && reg_addr == 8'h10 |=> !odd_field)
    else $error("odd field kept across mode write");
endmodule

bind vmt_timing_top vmt_timing_properties chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .low_power(low_power), .x_addr(x_addr), .y_addr(y_addr),
  .pix_valid(pix_valid), .black_line(black_line), .line_start(line_start),
  .field_start(field_start), .odd_field(odd_field), .qck_free_en(qck_free_en),
  .shuffle_en(shuffle_en));

/* vmt_coproc_model.sv */
`timescale 1ns/100ps
// Coprocessor side of the register port, one whole byte per strobe
module vmt_coproc_model (
  // Clock
  input wire ref_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Entered just after an edge; released lines turn inverted so stale data never looks valid
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      @(posedge ref_clk);
    end
  endtask

  // Read data is taken at the edge after the read strobe, where it already stands
  task rd(input logic [7:0] a, output logic [7:0] d);
    begin
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge ref_clk);
      d = reg_rdata;
    end
  endtask
endmodule

/* vmt_timing_top_test.sv */
`timescale 1ns/100ps
module vmt_timing_top_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic low_power = 1'b1;
  wire reg_wr, reg_rd, pix_valid, black_line, line_start, field_start, odd_field;
  wire qck_free_en, shuffle_en;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire [8:0] x_addr, y_addr;
  logic [7:0] d;
  logic [8:0] v;
  int fail_count = 0;
  int n_compared = 0;
  // Mode table: code, clock division, line and field lengths minus one
  logic [7:0] m_tab [8] = '{8'h00, 8'h08, 8'h01, 8'h09, 8'h02, 8'h0a, 8'h03, 8'h0b};
  logic [7:0] dv_tab [8] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h80, 8'h80, 8'h80, 8'h80};
  logic [8:0] ln_tab [8] = '{9'h19f, 9'h1f3, 9'h16b, 9'h1c5, 9'h0cf, 9'h0f9, 9'h0cf, 9'h0f9};
  logic [8:0] fd_tab [8] = '{9'h13f, 9'h13f, 9'h105, 9'h137, 9'h09f, 9'h09f, 9'h09f, 9'h09f};
  // Cropped offset writes and their clamped read-back
  logic [7:0] ca_tab [6] = '{8'h59, 8'h59, 8'h59, 8'h5b, 8'h5b, 8'h5b};
  logic [7:0] cd_tab [6] = '{8'h00, 8'hff, 8'h21, 8'h00, 8'hff, 8'h31};
  logic [7:0] ce_tab [6] = '{8'h01, 8'hb9, 8'h21, 8'h05, 8'h95, 8'h31};

  always #5 ref_clk = ~ref_clk;

  vmt_coproc_model cop (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  vmt_timing_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .low_power(low_power),
    .x_addr(x_addr), .y_addr(y_addr), .pix_valid(pix_valid), .black_line(black_line),
    .line_start(line_start), .field_start(field_start), .odd_field(odd_field),
    .qck_free_en(qck_free_en), .shuffle_en(shuffle_en));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_compared++;
      if (seen !== exp) begin
        fail_count++;
        $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task end_of_test;
    begin
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  // Nine-bit value from its high and low byte registers
  task rd9(input logic [7:0] a, output logic [8:0] val);
    logic [7:0] h;
    logic [7:0] l;
    begin
      cop.rd(a, h);
      cop.rd(a + 8'h01, l);
      val = {h[0], l};
    end
  endtask

  // Restart from low power, then measure the first line: start address, step, width, period
  task scan_check(input logic [8:0] fx, input logic [8:0] fy, input logic [8:0] sx,
    input int cnt, input int per);
    int c;
    int p;
    logic [8:0] x2;
    begin
      low_power <= 1'b1;
      @(posedge ref_clk);
      low_power <= 1'b0;
      p = 0;
      do begin
        @(negedge ref_clk);
        p++;
      end while (line_start !== 1'b1 && p < 9000);
      check(x_addr, fx);
      check(y_addr, fy);
      c = 0;
      p = 0;
      x2 = 9'h000;
      do begin
        if (pix_valid === 1'b1) begin
          c++;
          if (c == 2) x2 = x_addr;
        end
        @(negedge ref_clk);
        p++;
      end while (line_start !== 1'b1 && p < 9000);
      check(x2, sx);
      check(c, cnt);
      check(p, per);
      @(posedge ref_clk);
    end
  endtask

  // Short lines: extra black rows follow the image, then parity flips at the field end
  task field_check(input int pb, input int pf);
    int p;
    begin
      low_power <= 1'b1;
      @(posedge ref_clk);
      low_power <= 1'b0;
      p = 0;
      do begin
        @(negedge ref_clk);
        p++;
      end while (black_line !== 1'b1 && p < 20000);
      check(p, pb);
      check(y_addr, 9'h001);
      check(x_addr, 9'h005);
      check(odd_field, 1'b0);
      do begin
        @(negedge ref_clk);
        p++;
      end while (field_start !== 1'b1 && p < 20000);
      check(p, pf);
      check(odd_field, 1'b1);
      @(posedge ref_clk);
    end
  endtask

  // Hang guard: far more than the whole sequence needs
  initial begin
    #1000000;
    fail_count++;
    end_of_test;
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd9(8'h60, v);
    check(v, 9'h19f);
    rd9(8'h62, v);
    check(v, 9'h13f);
    cop.rd(8'h64, d);
    check(d, 8'h40);
    check(shuffle_en, 1'b1);
    check(qck_free_en, 1'b0);
    scan_check(9'h005, 9'h005, 9'h007, 356, 1664);
    cop.wr(8'h11, 8'h00);
    scan_check(9'h005, 9'h005, 9'h006, 356, 1664);
    cop.wr(8'h11, 8'h80);
    cop.wr(8'h64, 8'hf1);
    cop.rd(8'h64, d);
    check(d, 8'h41);
    scan_check(9'h005, 9'h005, 9'h007, 356, 3328);
    cop.wr(8'h10, 8'h00);
    cop.wr(8'h16, 8'h80);
    scan_check(9'h005, 9'h005, 9'h007, 356, 2496);
    cop.wr(8'h16, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cop.wr(8'h10, m_tab[i]);
      cop.rd(8'h64, d);
      check(d, dv_tab[i]);
      rd9(8'h60, v);
      check(v, ln_tab[i]);
      rd9(8'h62, v);
      check(v, fd_tab[i]);
      cop.rd(8'h11, d);
      check(d[5], m_tab[i][1:0] == 2'h1);
      check(qck_free_en, m_tab[i][1:0] == 2'h1);
    end
    cop.wr(8'h10, 8'h01);
    scan_check(9'h01d, 9'h01d, 9'h01f, 306, 728);
    cop.wr(8'h10, 8'h08);
    scan_check(9'h005, 9'h005, 9'h007, 356, 2000);
    cop.wr(8'h10, 8'h00);
    cop.wr(8'h64, 8'hf3);
    cop.wr(8'h61, 8'h00);
    cop.wr(8'h10, 8'h00);
    cop.rd(8'h64, d);
    check(d, 8'h40);
    rd9(8'h60, v);
    check(v, 9'h19f);
    cop.wr(8'h18, 8'h00);
    cop.wr(8'h10, 8'h00);
    cop.rd(8'h11, d);
    check(d[5], 1'b1);
    cop.wr(8'h60, 8'h00);
    cop.wr(8'h61, 8'h07);
    field_check(9350, 10246);
    cop.wr(8'h18, 8'h01);
    cop.wr(8'h14, 8'h04);
    check(qck_free_en, 1'b1);
    cop.wr(8'h14, 8'h05);
    check(qck_free_en, 1'b0);
    cop.wr(8'h10, 8'h02);
    cop.wr(8'h58, 8'h00);
    cop.wr(8'h5a, 8'h00);
    for (int i = 0; i < 6; i++) begin
      cop.wr(ca_tab[i], cd_tab[i]);
      cop.rd(ca_tab[i], d);
      check(d, ce_tab[i]);
    end
    cop.wr(8'h59, 8'h01);
    cop.wr(8'h5b, 8'h05);
    scan_check(9'h001, 9'h005, 9'h003, 180, 1664);
    end_of_test;
  end
endmodule
